// ===== src/susba_regs.vh
`ifndef SUSBA_REGS_VH
`define SUSBA_REGS_VH

// ***************************************************************
// register map
// ***************************************************************
`define SUSBA_OFS_BUS_LEVEL    8'h7a
`define SUSBA_OFS_I2C_BASE     8'h78
`define SUSBA_OFS_PMB_BASE     8'h79
`define SUSBA_OFS_RISE_STEP    8'h7b
`define SUSBA_OFS_TARGET       8'h7c
`define SUSBA_OFS_STATUS       8'h7d
`define SUSBA_BIT_BUS_LEVEL    2
`define SUSBA_RST_BUS_LEVEL    8'h00
`define SUSBA_RST_I2C_BASE     7'h08
`define SUSBA_RST_PMB_BASE     7'h70
`define SUSBA_RST_RISE_STEP    8'h01
`define SUSBA_RST_TARGET       10'h099
`define SUSBA_ALERT_ADDR       7'h0c

// ***************************************************************
// timing
// ***************************************************************
`define SUSBA_CLK_MHZ          200
`define SUSBA_SPIKE_NS         50
`define SUSBA_SPIKE_CYC        ((`SUSBA_SPIKE_NS * `SUSBA_CLK_MHZ + 999) / 1000)
`define SUSBA_TIMEOUT_US       200
`define SUSBA_TIMEOUT_CYC      (`SUSBA_TIMEOUT_US * `SUSBA_CLK_MHZ)
`define SUSBA_NVM_CYC          8'h10

`endif

// ===== src/susba_glitch_filter.v
`timescale 1ns/1ps
`default_nettype none
`include "susba_regs.vh"

// ***************************************************************
// spike filter: output follows input only after it held steady
// ***************************************************************
module susba_glitch_filter (
  input  wire clk_in,    // system clock
  input  wire resetn_in, // sync reset, low active
  input  wire raw_in,    // raw line level
  output reg  clean_out  // filtered level
);
  localparam integer HOLD_CYC = `SUSBA_SPIKE_CYC;
  localparam [3:0]   HOLD     = HOLD_CYC[3:0]; // 50 ns at 200 mhz fits in four bits
  reg [3:0] cnt;

  // a level shorter than the hold count is treated as a spike
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      cnt       <= 4'h0;
      clean_out <= 1'b1;
    end else if (raw_in == clean_out) begin
      cnt <= 4'h0;
    end else if (cnt == HOLD) begin
      cnt       <= 4'h0;
      clean_out <= raw_in;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== src/susba_startup.v
`timescale 1ns/1ps
`default_nettype none
`include "susba_regs.vh"

module susba_startup #(
  parameter TIMEOUT_CYC = `SUSBA_TIMEOUT_CYC
) (
  input  wire       clk_in,          // system clock, 200 mhz
  input  wire       resetn_in,       // sync reset, low active
  input  wire       supply_start_threshold_in, // bias above start level
  input  wire       nvm_done_in,     // memory copy finished
  input  wire [3:0] strap_band_in,   // band index from strap comparator
  input  wire       enable_pin_in,   // enable pin qualified
  input  wire       op_on_in,        // operation register on
  input  wire       onoff_cfg_ok_in, // on/off configuration agrees
  input  wire       vin_above_on_in, // input above turn-on level
  input  wire       precharge_ok_in, // pre-charge balanced
  input  wire       scl_in,          // bus clock level
  input  wire       sda_in,          // bus data level
  output wire       sda_out,         // data drive value, always 0
  output reg        sda_oe_out,      // low while pulling data low
  output reg        nvm_load_out,    // request memory copy
  output reg        bus_ready_out,   // bus slave open
  output reg        bus_level_out,   // 1: 3.3-5 v, 0: 1.8-2.5 v
  output reg        ramp_active_out, // soft-start running
  output reg [9:0]  reference_out,   // internal reference code
  output reg        min_pulse_out,   // minimum high-side pulse mode
  output reg [7:0]  high_side_pulse_out // on-time code
);
  // ***************************************************************
  // filtered bus lines
  // ***************************************************************
  wire scl_f;
  wire sda_f;

  susba_glitch_filter u_scl (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .raw_in    (scl_in),
    .clean_out (scl_f)
  );
  susba_glitch_filter u_sda (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .raw_in    (sda_in),
    .clean_out (sda_f)
  );

  // ***************************************************************
  // power-up sequencer
  // ***************************************************************
  localparam [2:0] S_RESET = 3'h0;
  localparam [2:0] S_LOAD  = 3'h1;
  localparam [2:0] S_STRAP = 3'h2;
  localparam [2:0] S_IDLE  = 3'h3;
  localparam [2:0] S_RAMP  = 3'h4;
  localparam [2:0] S_ON    = 3'h5;

  reg [2:0] state;
  reg [7:0] load_cnt;
  reg [3:0] offset;

  // registers
  reg [7:0] bus_level_config;
  reg [6:0] i2c_base;
  reg [6:0] pmb_base;
  reg [7:0] rise_step;
  reg [9:0] target;

  wire turn_on = enable_pin_in & op_on_in & onoff_cfg_ok_in & vin_above_on_in;

  // sequence: reset exit, memory copy, strap sample, then idle
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      state         <= S_RESET;
      load_cnt      <= 8'h00;
      offset        <= 4'h0;
      nvm_load_out  <= 1'b0;
      bus_ready_out <= 1'b0;
    end else begin
      case (state)
        S_RESET: begin
          if (supply_start_threshold_in) begin
            state        <= S_LOAD;
            nvm_load_out <= 1'b1;
            load_cnt     <= 8'h00;
          end
        end
        S_LOAD: begin
          if (load_cnt != `SUSBA_NVM_CYC) begin
            load_cnt <= load_cnt + 8'h01;
          end
          // wait a minimum settle time as well as the done flag
          if (nvm_done_in && load_cnt == `SUSBA_NVM_CYC) begin
            nvm_load_out <= 1'b0;
            state        <= S_STRAP;
          end
        end
        S_STRAP: begin
          offset        <= strap_band_in;
          bus_ready_out <= 1'b1;
          state         <= S_IDLE;
        end
        default: begin
          if (!supply_start_threshold_in) begin
            state         <= S_RESET;
            bus_ready_out <= 1'b0;
          end else if (state == S_IDLE && turn_on && precharge_ok_in) begin
            state <= S_RAMP;
          end else if (state != S_IDLE && !turn_on) begin
            state <= S_IDLE;
          end else if (state == S_RAMP && reference_out == target) begin
            state <= S_ON;
          end
        end
      endcase
    end
  end

  // active addresses: strap offset applies to both bases
  wire [6:0] i2c_addr = i2c_base + {3'h0, offset};
  wire [6:0] pmb_addr = pmb_base + {3'h0, offset};

  // ***************************************************************
  // soft-start ramp
  // ***************************************************************
  wire [9:0] step = {2'h0, rise_step};
  wire [9:0] gap  = target - reference_out;

  // reference rises one step per tick; snaps to target at the end
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      reference_out       <= 10'h000;
      ramp_active_out     <= 1'b0;
      min_pulse_out       <= 1'b0;
      high_side_pulse_out <= 8'h00;
    end else if (state == S_RAMP && turn_on) begin
      ramp_active_out <= 1'b1;
      if (reference_out < target) begin
        reference_out <= (gap > step) ? reference_out + step : target;
      end else begin
        reference_out <= target;
      end
      // start at the shortest on-time, then widen with the reference
      min_pulse_out       <= (reference_out[9:2] == 8'h00);
      high_side_pulse_out <= (reference_out[9:2] == 8'h00) ? 8'h01
                             : reference_out[9:2];
    end else if (state == S_ON && turn_on) begin
      ramp_active_out     <= 1'b0;
      min_pulse_out       <= 1'b0;
      reference_out       <= target;
      high_side_pulse_out <= target[9:2];
    end else begin
      // hard stop: reference pulled down at once
      reference_out       <= 10'h000;
      ramp_active_out     <= 1'b0;
      min_pulse_out       <= 1'b0;
      high_side_pulse_out <= 8'h00;
    end
  end

  // ***************************************************************
  // bus slave
  // ***************************************************************
  localparam [2:0] B_IDLE = 3'h0;
  localparam [2:0] B_ADDR = 3'h1;
  localparam [2:0] B_ACK  = 3'h2;
  localparam [2:0] B_DATA = 3'h3;
  localparam [2:0] B_SKIP = 3'h4;

  reg [2:0]  bst;
  reg [7:0]  shift;
  reg [3:0]  bitn;
  reg [1:0]  byten;
  reg [7:0]  ptr;
  reg        rd;
  reg        scl_d;
  reg        sda_d;
  reg [15:0] low_cnt;
  reg        ack_done;

  wire scl_rise = scl_f & ~scl_d;
  wire scl_fall = ~scl_f & scl_d;
  wire start_c  = scl_f & sda_d & ~sda_f;
  wire stop_c   = scl_f & ~sda_d & sda_f;
  wire timeout  = (low_cnt == TIMEOUT_CYC[15:0]);
  wire [7:0] nxt = {shift[6:0], sda_f};
  wire addr_hit = (nxt[7:1] == i2c_addr) || (nxt[7:1] == pmb_addr);

  reg [7:0] rdata;
  // read mux; unmapped offsets return zero
  always @* begin
    if (ptr == `SUSBA_OFS_BUS_LEVEL) begin
      rdata = bus_level_config;
    end else if (ptr == `SUSBA_OFS_I2C_BASE) begin
      rdata = {1'b0, i2c_base};
    end else if (ptr == `SUSBA_OFS_PMB_BASE) begin
      rdata = {1'b0, pmb_base};
    end else if (ptr == `SUSBA_OFS_RISE_STEP) begin
      rdata = rise_step;
    end else if (ptr == `SUSBA_OFS_TARGET) begin
      rdata = target[9:2];
    end else if (ptr == `SUSBA_OFS_STATUS) begin
      rdata = {1'b0, state, offset};
    end else begin
      rdata = 8'h00;
    end
  end

  assign sda_out = 1'b0;

  // byte-level slave; a data line held low too long drops the transfer
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      bst              <= B_IDLE;
      shift            <= 8'h00;
      bitn             <= 4'h0;
      byten            <= 2'h0;
      ptr              <= 8'h00;
      rd               <= 1'b0;
      scl_d            <= 1'b1;
      sda_d            <= 1'b1;
      low_cnt          <= 16'h0000;
      sda_oe_out       <= 1'b1;
      ack_done         <= 1'b0;
      bus_level_config <= `SUSBA_RST_BUS_LEVEL;
      i2c_base         <= `SUSBA_RST_I2C_BASE;
      pmb_base         <= `SUSBA_RST_PMB_BASE;
      rise_step        <= `SUSBA_RST_RISE_STEP;
      target           <= `SUSBA_RST_TARGET;
    end else begin
      scl_d   <= scl_f;
      sda_d   <= sda_f;
      low_cnt <= (sda_f || bst == B_IDLE) ? 16'h0000
                 : (timeout ? low_cnt : low_cnt + 16'h0001);
      if (!bus_ready_out) begin
        bst        <= B_IDLE;
        sda_oe_out <= 1'b1;
      end else if (timeout) begin
        bst        <= B_IDLE;
        sda_oe_out <= 1'b1;
      end else if (stop_c) begin
        bst        <= B_IDLE;
        sda_oe_out <= 1'b1;
      end else if (start_c) begin
        bst   <= B_ADDR;
        bitn  <= 4'h0;
        byten <= 2'h0;
      end else begin
        case (bst)
          B_ADDR, B_DATA: begin
            if (scl_fall && rd && bst == B_DATA) begin
              sda_oe_out <= rdata[3'h7 - bitn[2:0]];
            end
            if (scl_rise) begin
              shift <= nxt;
              bitn  <= bitn + 4'h1;
              if (bitn == 4'h7) begin
                bst <= B_ACK;
                ack_done <= 1'b0;
                if (bst == B_ADDR) begin
                  rd <= nxt[0];
                  if (!addr_hit) bst <= B_SKIP;
                end else if (rd) begin
                  ptr <= ptr + 8'h01;
                end else if (byten == 2'h1) begin
                  ptr <= nxt;
                end else begin
                  if (ptr == `SUSBA_OFS_BUS_LEVEL) bus_level_config <= nxt;
                  if (ptr == `SUSBA_OFS_I2C_BASE) i2c_base <= nxt[6:0];
                  if (ptr == `SUSBA_OFS_PMB_BASE) pmb_base <= nxt[6:0];
                  if (ptr == `SUSBA_OFS_RISE_STEP) rise_step <= nxt;
                  if (ptr == `SUSBA_OFS_TARGET) target <= {nxt, 2'h0};
                  ptr <= ptr + 8'h01;
                end
              end
            end
          end
          B_ACK: begin
            if (scl_rise) begin
              shift <= nxt; // master ack bit lands in shift[0]
            end
            // drive ack on the falling edge, release after the next one
            if (scl_fall && !ack_done) begin
              sda_oe_out <= rd & (byten != 2'h0);
              ack_done   <= 1'b1;
            end else if (scl_fall && rd && byten != 2'h0 && shift[0]) begin
              // master nack ends the read; holding data low would block the stop
              sda_oe_out <= 1'b1;
              bst        <= B_SKIP;
            end else if (scl_fall) begin
              sda_oe_out <= 1'b1;
              bitn       <= 4'h0;
              byten      <= (byten == 2'h3) ? 2'h3 : byten + 2'h1;
              bst        <= B_DATA;
              if (rd) sda_oe_out <= rdata[7];
            end
          end
          default: begin
            sda_oe_out <= 1'b1;
          end
        endcase
      end
    end
  end

  // bus level select drives the receiver range
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      bus_level_out <= 1'b0;
    end else begin
      bus_level_out <= bus_level_config[`SUSBA_BIT_BUS_LEVEL];
    end
  end
endmodule
`default_nettype wire

// ===== test/susba_chk.sv
`timescale 1ns/1ps
`default_nettype none
module susba_chk #(
  parameter int TIMEOUT_CYC = 40000
) (
  input wire logic       clk_in,                    // clock
  input wire logic       resetn_in,                 // sync reset
  input wire logic       supply_start_threshold_in, // bias ok
  input wire logic       nvm_done_in,               // copy done
  input wire logic       enable_pin_in,             // turn-on term
  input wire logic       op_on_in,                  // turn-on term
  input wire logic       onoff_cfg_ok_in,           // turn-on term
  input wire logic       vin_above_on_in,           // turn-on term
  input wire logic       precharge_ok_in,           // balanced
  input wire logic       sda_oe_out,                // data drive, low active
  input wire logic       nvm_load_out,              // copy running
  input wire logic       bus_ready_out,             // slave open
  input wire logic       ramp_active_out,           // ramp running
  input wire logic [9:0] reference_out,             // reference code
  input wire logic       min_pulse_out              // minimum pulse mode
);
  // ***************************************************************
  // helper counters
  // ***************************************************************
  wire         on_ok = enable_pin_in & op_on_in & onoff_cfg_ok_in & vin_above_on_in;
  wire         go_ok = on_ok & precharge_ok_in;
  logic [4:0]  ld_cnt;
  logic [17:0] lo_cnt;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // both saturate, so a long hold cannot wrap back under a bound
  always @(posedge clk_in) begin
    if (!resetn_in || !supply_start_threshold_in) ld_cnt <= 5'h00;
    else if (nvm_load_out && ld_cnt != 5'h1f) ld_cnt <= ld_cnt + 5'h01;
    if (!resetn_in || sda_oe_out) lo_cnt <= 18'h00000;
    else if (lo_cnt != 18'h3ffff) lo_cnt <= lo_cnt + 18'h00001;
  end
  property p_load; $rose(nvm_load_out) |-> $past(supply_start_threshold_in); endproperty
  a_load: assert property (p_load) else $error("load without supply");
  property p_ready; $rose(bus_ready_out) |-> ld_cnt >= 5'h0f && $past(nvm_done_in); endproperty
  a_ready: assert property (p_ready) else $error("bus opened early");
  property p_closed; !bus_ready_out |-> sda_oe_out; endproperty
  a_closed: assert property (p_closed) else $error("drive while closed");
  property p_gate; $rose(ramp_active_out) |-> $past(go_ok); endproperty
  a_gate: assert property (p_gate) else $error("ramp without turn-on");
  property p_rise;
    ramp_active_out && $past(ramp_active_out) |-> reference_out >= $past(reference_out);
  endproperty
  a_rise: assert property (p_rise) else $error("reference fell in ramp");
  property p_off; !on_ok |=> reference_out == 10'h000; endproperty
  a_off: assert property (p_off) else $error("reference kept when off");
  property p_min;
    min_pulse_out |-> reference_out < 10'h004 || $past(reference_out) < 10'h004;
  endproperty
  a_min: assert property (p_min) else $error("minimum pulse too late");
  property p_tmo; lo_cnt <= TIMEOUT_CYC + 64; endproperty
  a_tmo: assert property (p_tmo) else $error("data held low too long");
endmodule
bind susba_startup susba_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (
  .clk_in(clk_in), .resetn_in(resetn_in), .nvm_done_in(nvm_done_in),
  .supply_start_threshold_in(supply_start_threshold_in), .op_on_in(op_on_in),
  .enable_pin_in(enable_pin_in), .onoff_cfg_ok_in(onoff_cfg_ok_in),
  .vin_above_on_in(vin_above_on_in), .precharge_ok_in(precharge_ok_in),
  .sda_oe_out(sda_oe_out), .nvm_load_out(nvm_load_out), .bus_ready_out(bus_ready_out),
  .ramp_active_out(ramp_active_out), .reference_out(reference_out),
  .min_pulse_out(min_pulse_out)
);
`default_nettype wire

// ===== test/susba_host.sv
`timescale 1ns/1ps
`default_nettype none
module susba_host (
  input  wire logic clk_in,     // system clock
  input  wire logic sda_in,     // resolved data line
  output var  logic scl_out,    // bus clock
  output var  logic sda_drv_out // low pulls data down
);
  // ***************************************************************
  // bus master, all changes on falling clock edges
  // ***************************************************************
  localparam int H = 20;
  initial scl_out = 1'b1;
  initial sda_drv_out = 1'b1;
  task automatic hp;
    repeat (H) @(negedge clk_in);
  endtask
  // also serves as repeated start from a low clock
  task automatic start;
    sda_drv_out = 1'b1;
    hp;
    scl_out = 1'b1;
    hp;
    sda_drv_out = 1'b0;
    hp;
    scl_out = 1'b0;
    hp;
  endtask
  task automatic stop;
    sda_drv_out = 1'b0;
    hp;
    scl_out = 1'b1;
    hp;
    sda_drv_out = 1'b1;
    hp;
  endtask
  // a released bit gets a 15 ns low spike mid-high that must not read as a start
  task automatic bit_io(input logic bv, output logic rv);
    sda_drv_out = bv;
    hp;
    scl_out = 1'b1;
    repeat (H / 2) @(negedge clk_in);
    if (bv) begin
      sda_drv_out = 1'b0;
      repeat (3) @(negedge clk_in);
      sda_drv_out = 1'b1;
    end
    repeat (H / 2) @(negedge clk_in);
    rv = sda_in;
    scl_out = 1'b0;
    repeat (H / 2) @(negedge clk_in);
  endtask
  task automatic xfer(input logic [7:0] d, input logic mb, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int k = 7; k >= 0; k--) bit_io(d[k], q[k]);
    bit_io(mb, r);
    ack = ~r;
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d,
                        output logic ack);
    logic [7:0] t;
    logic       k1, k2, k3;
    start;
    xfer({a, 1'b0}, 1'b1, t, k1);
    xfer(o, 1'b1, t, k2);
    xfer(d, 1'b1, t, k3);
    stop;
    ack = k1 & k2 & k3;
  endtask
  // pointer write, repeated start, one byte read closed by a master nack
  task automatic rd_reg(input logic [6:0] a, input logic [7:0] o, output logic [7:0] q,
                        output logic ack);
    logic [7:0] t;
    logic       k1, k2, k3, k4;
    start;
    xfer({a, 1'b0}, 1'b1, t, k1);
    xfer(o, 1'b1, t, k2);
    start;
    xfer({a, 1'b1}, 1'b1, t, k3);
    xfer(8'hff, 1'b1, q, k4);
    stop;
    ack = k1 & k2 & k3;
  endtask
endmodule
`default_nettype wire

// ===== test/susba_startup_test.sv
`timescale 1ns/1ps
`default_nettype none
module susba_startup_test;
  // ***************************************************************
  // clock, wiring and checks
  // ***************************************************************
  localparam int TO = 1500; // must outlast a zero byte plus its ack
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        supply = 1'b0;
  logic        nvm_done = 1'b0;
  logic        pre = 1'b0;
  logic [3:0]  strap = 4'h0;
  logic [3:0]  qual = 4'h0;   // enable, operation, on/off config, input level
  wire         scl, sda_drv, sda_o, sda_oe, nvm_load, bus_ready, bus_level, ramp, min_p;
  wire  [9:0]  ref_code;
  wire  [7:0]  hsp;
  wire         sda = sda_drv & (sda_oe | sda_o); // open drain with pull-up
  int          error_cnt = 0;
  int          checks = 0;
  int          n, b, i;
  logic [7:0]  q;
  logic [9:0]  p;
  logic        ack;
  logic [24:0] rows [0:4] = '{{1'b1, 8'h04, 8'h7a, 8'h04}, {1'b0, 8'hfb, 8'h7a, 8'hfb},
    {1'b0, 8'h00, 8'h7a, 8'h00}, {1'b0, 8'h04, 8'h7b, 8'h04}, {1'b0, 8'h10, 8'h7c, 8'h10}};
  always #2.5 clk_in = ~clk_in;
  susba_startup #(.TIMEOUT_CYC(TO)) i_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .supply_start_threshold_in(supply),
    .nvm_done_in(nvm_done), .strap_band_in(strap), .enable_pin_in(qual[3]),
    .op_on_in(qual[2]), .onoff_cfg_ok_in(qual[1]), .vin_above_on_in(qual[0]),
    .precharge_ok_in(pre), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .nvm_load_out(nvm_load), .bus_ready_out(bus_ready),
    .bus_level_out(bus_level), .ramp_active_out(ramp), .reference_out(ref_code),
    .min_pulse_out(min_p), .high_side_pulse_out(hsp));
  susba_host i_host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_drv_out(sda_drv));
  task automatic end_of_test;
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // mid-run reset, supply up, copy done after 20 cycles, wait for the slave
  task automatic boot(input logic [3:0] bv);
    resetn_in = 1'b0;
    supply = 1'b0;
    nvm_done = 1'b0;
    strap = bv;
    repeat (16) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    supply = 1'b1;
    repeat (2) @(negedge clk_in);
    chk("nvm_load", 16'h1, {15'h0, nvm_load});
    repeat (20) @(negedge clk_in);
    nvm_done = 1'b1;
    for (n = 0; n < 40 && bus_ready !== 1'b1; n++) @(negedge clk_in);
    chk("nvm_load_end", 16'h0, {15'h0, nvm_load});
    if (bus_ready !== 1'b1) begin
      error_cnt++;
      end_of_test;
    end
  endtask
  initial begin
    repeat (95000) @(negedge clk_in);
    error_cnt++;
    end_of_test;
  end
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    repeat (16) @(negedge clk_in);
    chk("sda_oe_rst", 16'h1, {15'h0, sda_oe});
    chk("ref_rst", 16'h0, {6'h0, ref_code});
    resetn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    i_host.wr_reg(7'h08, 8'h7a, 8'h04, ack);
    chk("ack_closed", 16'h0, {15'h0, ack});
    // strap 4 under the default base would form the alert address, so it is left out
    for (b = 0; b < 16; b++) begin
      if (b == 4) continue;
      boot(b[3:0]);
      i_host.rd_reg(7'h70 + b[6:0], 8'h7d, q, ack);
      chk("ack_pmb", 16'h1, {15'h0, ack});
      chk("offset", b[15:0], {12'h0, q[3:0]});
    end
    boot(4'h3); // i2c address 0x0b stays clear of the alert address
    strap = 4'h9; // a late strap change must be ignored
    i_host.rd_reg(7'h11, 8'h7d, q, ack);
    chk("ack_late", 16'h0, {15'h0, ack});
    for (i = 0; i < 5; i++) begin
      i_host.wr_reg(7'h0b, rows[i][15:8], rows[i][7:0], ack);
      chk("ack_wr", 16'h1, {15'h0, ack});
      i_host.rd_reg(7'h0b, rows[i][15:8], q, ack);
      chk("rdback", {8'h0, rows[i][23:16]}, {8'h0, q});
      chk("bus_level", {15'h0, rows[i][24]}, {15'h0, bus_level});
    end
    // each turn-on term missing in turn, then pre-charge missing
    pre = 1'b1;
    for (i = 0; i < 4; i++) begin
      qual = 4'hf ^ (4'h1 << i);
      repeat (30) @(negedge clk_in);
      chk("ramp_part", 16'h0, {15'h0, ramp});
    end
    pre = 1'b0;
    qual = 4'hf;
    repeat (30) @(negedge clk_in);
    chk("ramp_nochg", 16'h0, {15'h0, ramp});
    pre = 1'b1;
    for (n = 0; n < 10 && ramp !== 1'b1; n++) @(negedge clk_in);
    chk("ramp_go", 16'h1, {15'h0, ramp});
    chk("min_pulse", 16'h1, {15'h0, min_p});
    chk("hsp_min", 16'h1, {8'h0, hsp});
    for (n = 0; n < 40 && ref_code !== 10'h040; n++) begin
      p = ref_code;
      @(negedge clk_in);
      if (ref_code !== 10'h040) chk("ref_step", {6'h0, p + 10'h004}, {6'h0, ref_code});
    end
    repeat (8) @(negedge clk_in);
    chk("ref_end", 16'h0040, {6'h0, ref_code});
    chk("min_pulse_end", 16'h0, {15'h0, min_p});
    chk("hsp_on", 16'h0010, {8'h0, hsp});
    qual = 4'h0;
    @(negedge clk_in);
    chk("ref_off", 16'h0, {6'h0, ref_code});
    repeat (200) @(negedge clk_in);
    // slave drives a zero read bit while the clock stalls low
    i_host.start;
    i_host.xfer({7'h0b, 1'b0}, 1'b1, q, ack);
    i_host.xfer(8'h7d, 1'b1, q, ack);
    i_host.start;
    i_host.xfer({7'h0b, 1'b1}, 1'b1, q, ack);
    repeat (40) @(negedge clk_in);
    chk("oe_hold", 16'h0, {15'h0, sda_oe});
    repeat (TO + 100) @(negedge clk_in);
    chk("oe_free", 16'h1, {15'h0, sda_oe});
    i_host.stop;
    i_host.rd_reg(7'h0b, 8'h7a, q, ack);
    chk("ack_again", 16'h1, {15'h0, ack});
    end_of_test;
  end
endmodule
`default_nettype wire
